// ---- hw/cat_pkg.sv ----
package cat_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned FILE_DEPTH = 128;

  // Register offsets in bytes.
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_OPERAND = 12'h004;
  localparam logic [11:0] OFS_W       = 12'h008;
  localparam logic [11:0] OFS_STATUS  = 12'h00c;
  localparam logic [11:0] OFS_DIR_A   = 12'h010;
  localparam logic [11:0] OFS_DIR_B   = 12'h014;
  localparam logic [11:0] OFS_DIR_C   = 12'h018;
  localparam logic [11:0] OFS_WDT     = 12'h01c;
  localparam logic [11:0] OFS_WDT_EN  = 12'h020;
  localparam logic [1:0]  FILE_WIN    = 2'h1;

  // Field positions.
  localparam int unsigned CTRL_OP_LSB = 0;
  localparam int unsigned CTRL_DEST   = 4;
  localparam int unsigned ST_C        = 0;
  localparam int unsigned ST_DC       = 1;
  localparam int unsigned ST_Z        = 2;
  localparam int unsigned ST_PD       = 3;
  localparam int unsigned ST_TO       = 4;
  localparam int unsigned ST_SLEEP    = 5;
  localparam int unsigned ST_ERR      = 6;

  // Operand limits and direction selects.
  localparam logic [7:0] FILE_ADDR_MAX = 8'h7f;
  localparam logic [7:0] DIR_SEL_A     = 8'h05;
  localparam logic [7:0] DIR_SEL_B     = 8'h06;
  localparam logic [7:0] DIR_SEL_C     = 8'h07;

  // Reset values.
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic       TO_RST  = 1'b1;
  localparam logic       PD_RST  = 1'b1;

  // Watchdog prescaler divide, in core clock cycles.
  localparam int unsigned WDT_PRESC_DIV = 32;

  typedef enum logic [3:0] {
    CAT_ROTATE_RIGHT_THROUGH_CARRY = 4'h0,
    CAT_SUBTRACT_FROM_LITERAL      = 4'h1,
    CAT_SUBTRACT_FROM_REGISTER     = 4'h2,
    CAT_SUBTRACT_REGISTER_WITH_BORROW = 4'h3,
    CAT_NIBBLE_SWAP                = 4'h4,
    CAT_XOR_WITH_LITERAL           = 4'h5,
    CAT_XOR_WITH_REGISTER          = 4'h6,
    CAT_LOAD_PORT_DIRECTION        = 4'h7,
    CAT_SLEEP                      = 4'h8
  } cat_op_t;

  typedef struct packed {
    logic [7:0] result;
    logic       c;
    logic       dc;
    logic       z;
    logic       upd_c;
    logic       upd_dc;
    logic       upd_z;
    logic       to_w;
  } cat_alu_out_t;

  typedef struct packed {
    logic [7:0] port_a_direction;
    logic [7:0] port_b_direction;
    logic [7:0] port_c_direction;
  } cat_dir_t;

endpackage : cat_pkg

// ---- hw/cat_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module cat_alu (
  // Operation
  input  wire cat_pkg::cat_op_t     i_op,
  input  wire logic                 i_dest,
  // Operands
  input  wire logic [7:0]           i_w,
  input  wire logic [7:0]           i_f,
  input  wire logic [7:0]           i_lit,
  input  wire logic                 i_carry,
  // Result
  output cat_pkg::cat_alu_out_t     o_alu
);

  logic [7:0] minuend;
  logic       cin;
  logic [4:0] lo_sum;
  logic [8:0] full_sum;

  always_comb begin
    minuend = (i_op == cat_pkg::CAT_SUBTRACT_FROM_LITERAL) ? i_lit : i_f;
    cin = (i_op == cat_pkg::CAT_SUBTRACT_REGISTER_WITH_BORROW) ? i_carry : 1'b1;
    lo_sum = {1'b0, minuend[3:0]} + {1'b0, ~i_w[3:0]} + {4'h0, cin};
    full_sum = {1'b0, minuend} + {1'b0, ~i_w} + {8'h00, cin};
    o_alu = '0;
    o_alu.to_w = ~i_dest;
    case (i_op)
      cat_pkg::CAT_ROTATE_RIGHT_THROUGH_CARRY: begin
        o_alu.result = {i_carry, i_f[7:1]};
        o_alu.c = i_f[0];
        o_alu.upd_c = 1'b1;
      end
      cat_pkg::CAT_SUBTRACT_FROM_LITERAL,
      cat_pkg::CAT_SUBTRACT_FROM_REGISTER,
      cat_pkg::CAT_SUBTRACT_REGISTER_WITH_BORROW: begin
        o_alu.result = full_sum[7:0];
        o_alu.c = full_sum[8];
        o_alu.dc = lo_sum[4];
        o_alu.upd_c = 1'b1;
        o_alu.upd_dc = 1'b1;
        o_alu.upd_z = 1'b1;
        if (i_op == cat_pkg::CAT_SUBTRACT_FROM_LITERAL) begin
          o_alu.to_w = 1'b1;
        end
      end
      cat_pkg::CAT_NIBBLE_SWAP: begin
        o_alu.result = {i_f[3:0], i_f[7:4]};
      end
      cat_pkg::CAT_XOR_WITH_LITERAL: begin
        o_alu.result = i_w ^ i_lit;
        o_alu.upd_z = 1'b1;
        o_alu.to_w = 1'b1;
      end
      cat_pkg::CAT_XOR_WITH_REGISTER: begin
        o_alu.result = i_w ^ i_f;
        o_alu.upd_z = 1'b1;
      end
      default: begin
        o_alu.result = i_w;
        o_alu.to_w = 1'b0;
      end
    endcase
    o_alu.z = (o_alu.result == 8'h00);
  end

endmodule : cat_alu
`default_nettype wire

// ---- hw/cat_wdt.sv ----
`timescale 1ns/1ps
`default_nettype none
module cat_wdt #(
  parameter int unsigned PRESC_DIV = cat_pkg::WDT_PRESC_DIV
) (
  // Clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  // Control
  input  wire logic       i_enable,
  input  wire logic       i_clear,
  // Status
  output logic [7:0]      o_count,
  output logic            o_timeout
);

  if (PRESC_DIV < 2 || PRESC_DIV > 65536) begin : g_bad_presc
    $error("cat_wdt: PRESC_DIV out of range");
  end

  typedef struct packed {
    logic [15:0] presc;
    logic [7:0]  count;
    logic        timeout;
  } cat_wdt_state_t;

  cat_wdt_state_t st_reg;
  cat_wdt_state_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.timeout = 1'b0;
    if (i_clear) begin
      st_next.presc = '0;
      st_next.count = 8'h00;
    end else if (i_enable) begin
      if (st_reg.presc == 16'(PRESC_DIV - 1)) begin
        st_next.presc = '0;
        st_next.count = st_reg.count + 8'h01;
        st_next.timeout = (st_reg.count == 8'hff);
      end else begin
        st_next.presc = st_reg.presc + 16'h0001;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_count = st_reg.count;
  assign o_timeout = st_reg.timeout;

endmodule : cat_wdt
`default_nettype wire

// ---- hw/cat_alu_tail.sv ----
// Overview of operation
// - Rotate right: carry into bit7, bit0 to carry.
// - File address 0..127; select 0 W, 1 file.
// - Literal minus W into W, flags updated.
// - Carry and digit carry clear on borrow.
// - File minus W to selected destination.
// - File minus W minus inverted carry.
// - Nibble swap, no flags touched.
// - W xor literal into W, zero only.
// - W xor file to destination, zero only.
// - Sleep clears power-down, sets time-out, clears watchdog.
// - Sleep refuses further instructions, setting error, until wake or time-out.
// - Operand 5/6/7 loads port A/B/C direction.
`timescale 1ns/1ps
`default_nettype none
module cat_alu_tail #(
  parameter int unsigned FILE_DEPTH = cat_pkg::FILE_DEPTH,
  parameter int unsigned PRESC_DIV  = cat_pkg::WDT_PRESC_DIV
) (
  // Clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  // Avalon-MM slave
  input  wire logic [11:0]          i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic [31:0]               o_avs_readdata,
  output logic                      o_avs_waitrequest,
  // Wake request
  input  wire logic                 i_wake,
  // Core outputs
  output cat_pkg::cat_dir_t         o_dir,
  output logic [7:0]                o_w,
  output logic                      o_sleep
);

  if (FILE_DEPTH != cat_pkg::FILE_DEPTH) begin : g_bad_depth
    $error("cat_alu_tail: FILE_DEPTH must be 128");
  end
  if (PRESC_DIV < 2 || PRESC_DIV > 65536) begin : g_bad_presc
    $error("cat_alu_tail: PRESC_DIV out of range");
  end

  typedef struct packed {
    logic [FILE_DEPTH-1:0][7:0] file;
    logic [7:0]                 w;
    logic [7:0]                 operand;
    logic [4:0]                 ctrl;
    logic                       c;
    logic                       dc;
    logic                       z;
    logic                       pd;
    logic                       to;
    logic                       sleep;
    logic                       err;
    logic                       wdt_en;
    cat_pkg::cat_dir_t          dir;
    logic                       ack;
    logic [7:0]                 rdata;
  } cat_core_state_t;

  cat_core_state_t       st_reg;
  cat_core_state_t       st_next;
  cat_pkg::cat_alu_out_t alu;
  cat_pkg::cat_op_t      op;
  logic                  dest;
  logic [6:0]            fidx;
  logic [7:0]            fval;
  logic                  wr_take;
  logic                  exec;
  logic                  refuse;
  logic                  uses_file;
  logic                  wdt_clear;
  logic                  wdt_timeout;
  logic [7:0]            wdt_count;
  logic                  in_file_win;
  logic [6:0]            bus_idx;

  always_comb begin
    op = cat_pkg::cat_op_t'(i_avs_writedata[cat_pkg::CTRL_OP_LSB +: 4]);
    dest = i_avs_writedata[cat_pkg::CTRL_DEST];
    fidx = st_reg.operand[6:0];
    fval = st_reg.file[fidx];
    in_file_win = (i_avs_address[11:10] == cat_pkg::FILE_WIN);
    bus_idx = i_avs_address[8:2];
  end

  cat_alu u_alu (
    .i_op    (op),
    .i_dest  (dest),
    .i_w     (st_reg.w),
    .i_f     (fval),
    .i_lit   (st_reg.operand),
    .i_carry (st_reg.c),
    .o_alu   (alu)
  );

  cat_wdt #(
    .PRESC_DIV (PRESC_DIV)
  ) u_wdt (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_enable  (st_reg.wdt_en),
    .i_clear   (wdt_clear),
    .o_count   (wdt_count),
    .o_timeout (wdt_timeout)
  );

  always_comb begin
    wr_take = i_avs_write & st_reg.ack & i_avs_byteenable[0];
    exec = wr_take & (i_avs_address == cat_pkg::OFS_CTRL);
    case (op)
      cat_pkg::CAT_ROTATE_RIGHT_THROUGH_CARRY,
      cat_pkg::CAT_SUBTRACT_FROM_REGISTER,
      cat_pkg::CAT_SUBTRACT_REGISTER_WITH_BORROW,
      cat_pkg::CAT_NIBBLE_SWAP,
      cat_pkg::CAT_XOR_WITH_REGISTER: begin
        uses_file = 1'b1;
      end
      default: begin
        uses_file = 1'b0;
      end
    endcase
    refuse = 1'b0;
    if (st_reg.sleep) begin
      refuse = 1'b1;
    end else if (uses_file && st_reg.operand > cat_pkg::FILE_ADDR_MAX) begin
      refuse = 1'b1;
    end else if (op == cat_pkg::CAT_LOAD_PORT_DIRECTION) begin
      refuse = (st_reg.operand < cat_pkg::DIR_SEL_A) || (st_reg.operand > cat_pkg::DIR_SEL_C);
    end else if (i_avs_writedata[3:0] > 4'(cat_pkg::CAT_SLEEP)) begin
      refuse = 1'b1;
    end
    wdt_clear = exec & ~refuse & (op == cat_pkg::CAT_SLEEP);
  end

  always_comb begin
    st_next = st_reg;
    // Every access takes one wait state; read data loads at the end of it, writes land on the accepting edge.
    st_next.ack = (i_avs_read | i_avs_write) & ~st_reg.ack;
    if (i_avs_read && !st_reg.ack) begin
      st_next.rdata = 8'h00;
      if (in_file_win) begin
        st_next.rdata = st_reg.file[bus_idx];
      end else begin
        case (i_avs_address)
          cat_pkg::OFS_CTRL: begin
            st_next.rdata = {3'h0, st_reg.ctrl};
          end
          cat_pkg::OFS_OPERAND: begin
            st_next.rdata = st_reg.operand;
          end
          cat_pkg::OFS_W: begin
            st_next.rdata = st_reg.w;
          end
          cat_pkg::OFS_STATUS: begin
            st_next.rdata[cat_pkg::ST_C] = st_reg.c;
            st_next.rdata[cat_pkg::ST_DC] = st_reg.dc;
            st_next.rdata[cat_pkg::ST_Z] = st_reg.z;
            st_next.rdata[cat_pkg::ST_PD] = st_reg.pd;
            st_next.rdata[cat_pkg::ST_TO] = st_reg.to;
            st_next.rdata[cat_pkg::ST_SLEEP] = st_reg.sleep;
            st_next.rdata[cat_pkg::ST_ERR] = st_reg.err;
          end
          cat_pkg::OFS_DIR_A: begin
            st_next.rdata = st_reg.dir.port_a_direction;
          end
          cat_pkg::OFS_DIR_B: begin
            st_next.rdata = st_reg.dir.port_b_direction;
          end
          cat_pkg::OFS_DIR_C: begin
            st_next.rdata = st_reg.dir.port_c_direction;
          end
          cat_pkg::OFS_WDT: begin
            st_next.rdata = wdt_count;
          end
          cat_pkg::OFS_WDT_EN: begin
            st_next.rdata = {7'h00, st_reg.wdt_en};
          end
          default: begin
            st_next.rdata = 8'h00;
          end
        endcase
      end
    end

    // Plain register writes.
    if (wr_take) begin
      if (in_file_win) begin
        st_next.file[bus_idx] = i_avs_writedata[7:0];
      end else begin
        case (i_avs_address)
          cat_pkg::OFS_OPERAND: begin
            st_next.operand = i_avs_writedata[7:0];
          end
          cat_pkg::OFS_W: begin
            st_next.w = i_avs_writedata[7:0];
          end
          cat_pkg::OFS_STATUS: begin
            st_next.c = i_avs_writedata[cat_pkg::ST_C];
            st_next.dc = i_avs_writedata[cat_pkg::ST_DC];
            st_next.z = i_avs_writedata[cat_pkg::ST_Z];
            if (i_avs_writedata[cat_pkg::ST_ERR]) begin
              st_next.err = 1'b0;
            end
          end
          cat_pkg::OFS_WDT_EN: begin
            st_next.wdt_en = i_avs_writedata[0];
          end
          default: begin
          end
        endcase
      end
    end

    // A watchdog time-out or wake request ends sleep.
    if (wdt_timeout) begin
      st_next.to = 1'b0;
      st_next.sleep = 1'b0;
    end
    if (i_wake) begin
      st_next.sleep = 1'b0;
    end

    // Instruction execution on a write to the control register.
    if (exec) begin
      st_next.ctrl = i_avs_writedata[4:0];
      if (refuse) begin
        st_next.err = 1'b1;
      end else begin
        case (op)
          cat_pkg::CAT_LOAD_PORT_DIRECTION: begin
            case (st_reg.operand)
              cat_pkg::DIR_SEL_A: begin
                st_next.dir.port_a_direction = st_reg.w;
              end
              cat_pkg::DIR_SEL_B: begin
                st_next.dir.port_b_direction = st_reg.w;
              end
              default: begin
                st_next.dir.port_c_direction = st_reg.w;
              end
            endcase
          end
          cat_pkg::CAT_SLEEP: begin
            st_next.pd = 1'b0;
            st_next.to = 1'b1;
            st_next.sleep = 1'b1;
          end
          default: begin
            if (alu.to_w) begin
              st_next.w = alu.result;
            end else begin
              st_next.file[fidx] = alu.result;
            end
            if (alu.upd_c) begin
              st_next.c = alu.c;
            end
            if (alu.upd_dc) begin
              st_next.dc = alu.dc;
            end
            if (alu.upd_z) begin
              st_next.z = alu.z;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.pd <= cat_pkg::PD_RST;
      st_reg.to <= cat_pkg::TO_RST;
      st_reg.dir <= {3{cat_pkg::DIR_RST}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~st_reg.ack;
  assign o_avs_readdata = {24'h000000, st_reg.rdata};
  assign o_dir = st_reg.dir;
  assign o_w = st_reg.w;
  assign o_sleep = st_reg.sleep;

endmodule : cat_alu_tail
`default_nettype wire

// ---- verification/cat_alu_tail_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module cat_alu_tail_checker (
  // Clock and reset
  input wire logic              i_ref_clk,
  input wire logic              i_rst,
  // Bus and core
  input wire logic              i_avs_read,
  input wire logic              i_avs_write,
  input wire logic              i_wake,
  input wire logic [31:0]       o_avs_readdata,
  input wire logic              o_avs_waitrequest,
  input wire cat_pkg::cat_dir_t o_dir,
  input wire logic [7:0]        o_w,
  input wire logic              o_sleep
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic req;
  logic wacc;
  assign req = i_avs_read || i_avs_write;
  assign wacc = i_avs_write && !o_avs_waitrequest;
  one_wait_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request waited more than one cycle");
  idle_wait_a: assert property (!req |-> !o_avs_waitrequest)
    else $error("wait raised without a request");
  upper_zero_a: assert property (o_avs_readdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  rdata_hold_a: assert property (!(i_avs_read && o_avs_waitrequest) |=> $stable(o_avs_readdata))
    else $error("read data moved without a read");
  w_cause_a: assert property (!$stable(o_w) |-> $past(wacc))
    else $error("working register changed without a write");
  dir_cause_a: assert property (!$stable(o_dir) |-> $past(wacc))
    else $error("direction changed without a write");
  dir_value_a: assert property (!$stable(o_dir.port_a_direction) |-> o_dir.port_a_direction == $past(o_w))
    else $error("port A direction not loaded from W");
  sleep_cause_a: assert property ($rose(o_sleep) |-> $past(wacc))
    else $error("sleep entered without an instruction");
  wake_up_a: assert property (o_sleep && i_wake |=> !o_sleep)
    else $error("wake did not end sleep");
  asleep_dir_a: assert property ($past(o_sleep) && o_sleep |-> $stable(o_dir))
    else $error("direction changed while asleep");
  cover property (i_avs_read && !o_avs_waitrequest);
  cover property ($rose(o_sleep));
  cover property (o_sleep && i_wake);
  cover property ($fell(o_sleep) && !$past(i_wake));
endmodule : cat_alu_tail_checker
bind cat_alu_tail cat_alu_tail_checker chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_wake(i_wake), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_dir(o_dir), .o_w(o_w), .o_sleep(o_sleep));
`default_nettype wire

// ---- verification/cat_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module cat_host (
  // Clock
  input wire logic         i_ref_clk,
  // Avalon-MM master
  output logic [11:0]      o_address,
  output logic             o_read,
  output logic             o_write,
  output logic [31:0]      o_writedata,
  output logic [3:0]       o_byteenable,
  input wire logic [31:0]  i_readdata,
  input wire logic         i_waitrequest,
  // Hang flag
  output logic             o_hung
);
  initial begin
    o_address = 12'h000;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = 32'h00000000;
    o_byteenable = 4'h0;
    o_hung = 1'b0;
  end
  // One transfer; the request holds until waitrequest is sampled low.
  task automatic xfer(input logic rd, input logic [11:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    o_read <= rd;
    o_write <= !rd;
    o_address <= a;
    o_writedata <= {24'h000000, d};
    o_byteenable <= be;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (i_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) o_hung <= 1'b1;
    q = i_readdata[7:0];
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Released lines show no stale value.
    o_address <= ~a;
    o_writedata <= ~o_writedata;
  endtask : xfer
endmodule : cat_host
`default_nettype wire

// ---- verification/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [3:0] op; logic d; logic [7:0] w, f, k; logic c; logic [7:0] r; logic [2:0] fl;
  } cat_row_t;
  localparam cat_row_t ROWS [12] = '{
    '{4'h0, 1'b1, 8'h00, 8'h81, 8'h10, 1'b0, 8'h40, 3'h1}, '{4'h0, 1'b0, 8'h00, 8'h02, 8'h10, 1'b1, 8'h81, 3'h0},
    '{4'h1, 1'b0, 8'h03, 8'h00, 8'h05, 1'b0, 8'h02, 3'h3}, '{4'h1, 1'b0, 8'h05, 8'h00, 8'h03, 1'b0, 8'hfe, 3'h0},
    '{4'h2, 1'b1, 8'h01, 8'h10, 8'h10, 1'b0, 8'h0f, 3'h1}, '{4'h2, 1'b0, 8'h22, 8'h22, 8'h10, 1'b0, 8'h00, 3'h7},
    '{4'h3, 1'b0, 8'h0f, 8'h10, 8'h10, 1'b0, 8'h00, 3'h5}, '{4'h3, 1'b1, 8'h0f, 8'h10, 8'h10, 1'b1, 8'h01, 3'h1},
    '{4'h4, 1'b1, 8'h00, 8'ha5, 8'h10, 1'b1, 8'h5a, 3'h1}, '{4'h5, 1'b0, 8'h5a, 8'h00, 8'h5a, 1'b1, 8'h00, 3'h5},
    '{4'h6, 1'b1, 8'h0f, 8'hf0, 8'h10, 1'b0, 8'hff, 3'h0}, '{4'h6, 1'b0, 8'h33, 8'h33, 8'h10, 1'b0, 8'h00, 3'h4}};
  logic               i_ref_clk;
  logic               i_rst = 1'b1;
  logic               i_wake = 1'b0;
  logic [11:0]        adr;
  logic               rd;
  logic               wr;
  logic [31:0]        wdat;
  logic [31:0]        rdat;
  logic [3:0]         be;
  logic               wq;
  logic               hung;
  logic               slp;
  logic [7:0]         w;
  logic [7:0]         q;
  cat_pkg::cat_dir_t  dir;
  int                 n_errors = 0;
  int                 checks_done = 0;
  cat_host host (.i_ref_clk(i_ref_clk), .o_address(adr), .o_read(rd), .o_write(wr), .o_writedata(wdat),
    .o_byteenable(be), .i_readdata(rdat), .i_waitrequest(wq), .o_hung(hung));
  cat_alu_tail #(.FILE_DEPTH(128), .PRESC_DIV(2)) dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_wake(i_wake), .o_dir(dir), .o_w(w), .o_sleep(slp));
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bw(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b0, a, d, 4'h1, x);
  endtask : bw
  task automatic br(input logic [11:0] a, output logic [7:0] x);
    host.xfer(1'b1, a, 8'h00, 4'h1, x);
  endtask : br
  always @(posedge i_ref_clk) begin
    if (hung === 1'b1) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(negedge i_ref_clk);
    chk(w, 8'h00);
    chk({7'h00, slp}, 8'h00);
    chk(dir.port_a_direction & dir.port_b_direction & dir.port_c_direction, cat_pkg::DIR_RST);
    br(cat_pkg::OFS_STATUS, q);
    chk(q, 8'h18);
    br(12'h200, q);
    chk(q, 8'h00);
    host.xfer(1'b0, cat_pkg::OFS_W, 8'h77, 4'h0, q);
    br(cat_pkg::OFS_W, q);
    chk(q, 8'h00);
    foreach (ROWS[i]) begin
      bw(cat_pkg::OFS_W, ROWS[i].w);
      bw(12'h440, ROWS[i].f);
      bw(cat_pkg::OFS_STATUS, {7'h20, ROWS[i].c});
      bw(cat_pkg::OFS_OPERAND, ROWS[i].k);
      bw(cat_pkg::OFS_CTRL, {3'h0, ROWS[i].d, ROWS[i].op});
      br(ROWS[i].d ? 12'h440 : cat_pkg::OFS_W, q);
      chk(q, ROWS[i].r);
      chk(w, ROWS[i].d ? ROWS[i].w : ROWS[i].r);
      br(cat_pkg::OFS_STATUS, q);
      chk(q & 8'h47, {5'h00, ROWS[i].fl});
    end
    bw(cat_pkg::OFS_STATUS, 8'h47);
    for (int i = 0; i < 3; i++) begin
      bw(cat_pkg::OFS_W, 8'(8'h11 * (i + 1)));
      bw(cat_pkg::OFS_OPERAND, 8'(cat_pkg::DIR_SEL_A + i));
      bw(cat_pkg::OFS_CTRL, 8'h07);
    end
    @(negedge i_ref_clk);
    chk(dir.port_a_direction, 8'h11);
    chk(dir.port_b_direction, 8'h22);
    chk(dir.port_c_direction, 8'h33);
    br(cat_pkg::OFS_STATUS, q);
    chk(q, 8'h1f);
    bw(cat_pkg::OFS_OPERAND, 8'h08);
    bw(cat_pkg::OFS_CTRL, 8'h07);
    br(cat_pkg::OFS_STATUS, q);
    chk(q & 8'h40, 8'h40);
    bw(cat_pkg::OFS_STATUS, 8'h40);
    bw(cat_pkg::OFS_OPERAND, 8'h80);
    bw(cat_pkg::OFS_CTRL, 8'h12);
    br(cat_pkg::OFS_STATUS, q);
    chk(q & 8'h40, 8'h40);
    chk(w, 8'h33);
    bw(cat_pkg::OFS_WDT_EN, 8'h01);
    repeat (40) @(posedge i_ref_clk);
    bw(cat_pkg::OFS_CTRL, 8'h08);
    br(cat_pkg::OFS_WDT, q);
    chk({7'h00, q <= 8'h01}, 8'h01);
    br(cat_pkg::OFS_STATUS, q);
    chk(q & 8'h38, 8'h30);
    chk({7'h00, slp}, 8'h01);
    bw(cat_pkg::OFS_OPERAND, 8'hff);
    bw(cat_pkg::OFS_CTRL, 8'h05);
    @(negedge i_ref_clk);
    chk(w, 8'h33);
    br(cat_pkg::OFS_STATUS, q);
    chk(q & 8'h40, 8'h40);
    @(posedge i_ref_clk);
    i_wake <= 1'b1;
    @(posedge i_ref_clk);
    i_wake <= 1'b0;
    @(negedge i_ref_clk);
    chk({7'h00, slp}, 8'h00);
    bw(cat_pkg::OFS_STATUS, 8'h40);
    bw(cat_pkg::OFS_CTRL, 8'h09);
    br(cat_pkg::OFS_STATUS, q);
    chk(q & 8'h40, 8'h40);
    bw(cat_pkg::OFS_STATUS, 8'h40);
    bw(cat_pkg::OFS_OPERAND, 8'h0f);
    bw(cat_pkg::OFS_CTRL, 8'h15);
    br(cat_pkg::OFS_W, q);
    chk(q, 8'h3c);
    bw(cat_pkg::OFS_CTRL, 8'h08);
    @(negedge i_ref_clk);
    chk({7'h00, slp}, 8'h01);
    for (int t = 0; t < 600 && slp === 1'b1; t++) begin
      @(posedge i_ref_clk);
    end
    br(cat_pkg::OFS_STATUS, q);
    chk(q & 8'h38, 8'h00);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(negedge i_ref_clk);
    chk(w, 8'h00);
    chk(dir.port_a_direction, cat_pkg::DIR_RST);
    br(cat_pkg::OFS_STATUS, q);
    chk(q, 8'h18);
    print_verdict();
  end
endmodule : tb
`default_nettype wire
